// ### common/plls_pkg.sv
// plls_pkg: shared constants and carrier types for the dual pll control core
// assumes one 125 mhz system clock; serial pins already synchronous to it
package plls_pkg;
    localparam int SR_W        = 23;   // shift register length
    localparam int SEL_LO_POS  = 0;    // latch select low bit position
    localparam int SEL_HI_POS  = 1;    // latch select high bit position
    localparam int LAT_W       = 21;   // payload bits kept per latch
    localparam int LAT_LSB     = 2;
    localparam int NUM_LATCH   = 4;
    // latch select codes: {hi,lo}
    localparam logic [1:0] SEL_IF_REF = 2'h0;
    localparam logic [1:0] SEL_RF_REF = 2'h1;
    localparam logic [1:0] SEL_IF_DIV = 2'h2;
    localparam logic [1:0] SEL_RF_DIV = 2'h3;
    // lock windows, in reference periods
    localparam logic [3:0] UPPER_WIN  = 4'h2;  // upper error window
    localparam logic [3:0] LOWER_WIN  = 4'h4;  // lower error window
    localparam logic [1:0] LOCK_CYC   = 2'h3;  // consecutive good compares
    // wake-up limiting: error pulses capped for a number of compares
    localparam logic [3:0] START_CAP  = 4'h1;  // max pulse length, periods
    localparam logic [2:0] START_CMP  = 3'h4;  // limited compare count
    localparam logic [3:0] ERR_SAT    = 4'hf;
    localparam logic [3:0] ANTI_DEAD  = 4'h1;  // minimum pulse, periods

    typedef struct packed {
        logic data;
        logic clk;
        logic load_strobe;
    } plls_serial_t;

    typedef struct packed {
        logic up;
        logic dn;
        logic oe;
    } plls_pd_t;

    typedef struct packed {
        logic [LAT_W-1:0] if_ref;
        logic [LAT_W-1:0] rf_ref;
        logic [LAT_W-1:0] if_div;
        logic [LAT_W-1:0] rf_div;
    } plls_latch_t;
endpackage : plls_pkg

// ### core/plls_core.sv
// plls_core: serial load, per-section standby, phase detector gating and
// the combined lock indicator of a dual pll synthesizer.
// assumes reference and comparison edges arrive as one-cycle pulses on clk_sys
// and that one reference period is one clk_sys cycle of reference_osc_in.
//
// Operation
// RL1: power_save_n low puts a section into standby; high resumes operation.
// RL2: in standby the section's phase detector output is high impedance.
// RL3: after wake-up, phase detector error pulses are limited in length.
// RL4: host holds power-save inputs low from power-on.
// RL5: host waits at least 1 us after supply before shifting data.
// RL6: host releases standby at least 100 ns after the serial load.
// RL7: data bit taken on serial clock rise; latch loaded on strobe rise.
// RL8: host keeps load strobe low while shifting bits.
// RL9: lock indicator high only if each section is locked or in standby.
// RL10: lock indicator falls when phase error reaches the upper window.
// RL11: lock rises after three compares within the lower error window; code counts only compares with error below UPPER_WIN.
// RL12: short phase detector pulses continue while locked, avoiding dead zone.
// RL13: phase comparator detects errors from minus to plus two pi.
// RL14: host should keep an unused section in standby.
// RL15: strobe rise routes the shift register to one of four latches.
// RL16: host shifts each word most significant bit first.
// RL17: each section enters and leaves standby independently.
`timescale 1ns/1ns
module plls_core (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    // serial configuration pins
    input  wire plls_pkg::plls_serial_t ser_in,
    // standby controls
    input  wire logic                 if_power_save_n,
    input  wire logic                 rf_power_save_n,
    // reference and comparison edges, one pulse per edge
    input  wire logic                 reference_osc_in,
    input  wire logic [1:0]           ref_edge,
    input  wire logic [1:0]           cmp_edge,
    // phase detector outputs, index 0 = if, 1 = rf
    output plls_pkg::plls_pd_t        pd_out [2],
    // configuration and status
    output plls_pkg::plls_latch_t     latches,
    output logic                      lock_indicator
);
    typedef struct packed {
        logic                          clk_q;
        logic                          strobe_q;
        logic [plls_pkg::SR_W-1:0]     shreg;
        plls_pkg::plls_latch_t         lat;
        logic [1:0]                    up;      // reference led, pulse active
        logic [1:0]                    dn;      // comparison led, pulse active
        logic [1:0][3:0]               err;     // error length, ref periods
        logic [1:0][3:0]               plen;    // pulse length so far
        logic [1:0][1:0]               good;    // consecutive good compares
        logic [1:0]                    locked;
        logic [1:0][2:0]               wake;    // limited compares left
        logic [1:0]                    awake_q;
        logic                          ld;
    } plls_state_t;

    plls_state_t st_ff;
    plls_state_t nxt_st;
    logic [1:0]  awake;

    assign awake = {rf_power_save_n, if_power_save_n}; // RL1 RL17

    always_comb begin
        logic done;
        logic [3:0] meas;
        done   = 1'b0;
        meas   = 4'h0;
        nxt_st = st_ff;
        nxt_st.clk_q    = ser_in.clk;
        nxt_st.strobe_q = ser_in.load_strobe;
        if (ser_in.clk && !st_ff.clk_q) begin
            nxt_st.shreg = {st_ff.shreg[plls_pkg::SR_W-2:0], ser_in.data}; // RL7
        end
        if (ser_in.load_strobe && !st_ff.strobe_q) begin // RL7
            // select bits arrive last, so they sit at the low end
            if (st_ff.shreg[1:0] == plls_pkg::SEL_IF_REF) begin // RL15
                nxt_st.lat.if_ref = st_ff.shreg[plls_pkg::SR_W-1:2];
            end else if (st_ff.shreg[1:0] == plls_pkg::SEL_RF_REF) begin
                nxt_st.lat.rf_ref = st_ff.shreg[plls_pkg::SR_W-1:2];
            end else if (st_ff.shreg[1:0] == plls_pkg::SEL_IF_DIV) begin
                nxt_st.lat.if_div = st_ff.shreg[plls_pkg::SR_W-1:2];
            end else begin
                nxt_st.lat.rf_div = st_ff.shreg[plls_pkg::SR_W-1:2];
            end
        end
        for (int s = 0; s < 2; s++) begin
            nxt_st.awake_q[s] = awake[s];
            if (!awake[s]) begin // RL2
                nxt_st.up[s]     = 1'b0;
                nxt_st.dn[s]     = 1'b0;
                nxt_st.err[s]    = 4'h0;
                nxt_st.plen[s]   = 4'h0;
                nxt_st.good[s]   = 2'h0;
                nxt_st.locked[s] = 1'b0;
                nxt_st.wake[s]   = plls_pkg::START_CMP;
            end else begin
                // a single tri-state detector spans a full cycle each way
                done = 1'b0; // RL13
                if (ref_edge[s] && cmp_edge[s]) begin
                    done = st_ff.up[s] || st_ff.dn[s];
                    nxt_st.up[s] = 1'b0;
                    nxt_st.dn[s] = 1'b0;
                end else if (ref_edge[s]) begin
                    done = st_ff.dn[s];
                    nxt_st.up[s] = !st_ff.dn[s];
                    nxt_st.dn[s] = 1'b0;
                end else if (cmp_edge[s]) begin
                    done = st_ff.up[s];
                    nxt_st.dn[s] = !st_ff.up[s];
                    nxt_st.up[s] = 1'b0;
                end
                if (st_ff.up[s] || st_ff.dn[s]) begin
                    if (st_ff.err[s] != plls_pkg::ERR_SAT) begin
                        nxt_st.err[s] = st_ff.err[s] + 4'h1;
                    end
                end
                if ((ref_edge[s] || cmp_edge[s]) && !done
                    && !(ref_edge[s] && cmp_edge[s])) begin
                    nxt_st.err[s] = 4'h0;
                end
                // pulse length, 1 in the first cycle of a pulse; either
                // leg restarts it so both legs get the same wake-up cap
                if (!nxt_st.up[s] && !nxt_st.dn[s]) begin
                    nxt_st.plen[s] = 4'h0;
                end else if (!st_ff.up[s] && !st_ff.dn[s]) begin
                    nxt_st.plen[s] = 4'h1;
                end else if (st_ff.plen[s] != plls_pkg::ERR_SAT) begin
                    nxt_st.plen[s] = st_ff.plen[s] + 4'h1;
                end
                if (done || (ref_edge[s] && cmp_edge[s])) begin
                    if (st_ff.wake[s] != 3'h0) begin
                        nxt_st.wake[s] = st_ff.wake[s] - 3'h1; // RL3
                    end
                    // the closing edge counts as one more period
                    meas = (st_ff.up[s] || st_ff.dn[s]) ? nxt_st.err[s]
                                                        : 4'h0;
                    if (meas >= plls_pkg::UPPER_WIN) begin // RL10
                        nxt_st.good[s]   = 2'h0;
                        nxt_st.locked[s] = 1'b0;
                    end else if (meas <= plls_pkg::LOWER_WIN) begin
                        if (st_ff.good[s] != plls_pkg::LOCK_CYC) begin
                            nxt_st.good[s] = st_ff.good[s] + 2'h1;
                        end
                        if (st_ff.good[s] >= 2'h2) begin // RL11
                            nxt_st.locked[s] = 1'b1;
                        end
                    end
                end
            end
        end
        nxt_st.ld = (nxt_st.locked[0] || !awake[0])
                 && (nxt_st.locked[1] || !awake[1]); // RL9
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs: width limited while waking, minimum pulse while locked
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            pd_out[s].oe = st_ff.awake_q[s] && awake[s]; // RL2
            pd_out[s].up = pd_out[s].oe && st_ff.up[s]
                && (st_ff.wake[s] == 3'h0
                    || st_ff.plen[s] <= plls_pkg::START_CAP); // RL3
            pd_out[s].dn = pd_out[s].oe && st_ff.dn[s]
                && (st_ff.wake[s] == 3'h0
                    || st_ff.plen[s] <= plls_pkg::START_CAP);
            if (pd_out[s].oe && st_ff.locked[s] && ref_edge[s]) begin
                // both legs briefly on: charge cancels, no dead zone
                pd_out[s].up = 1'b1; // RL12
                pd_out[s].dn = 1'b1;
            end
        end
    end

    assign latches        = st_ff.lat;
    assign lock_indicator = st_ff.ld;

    property p_standby_hiz;
        @(posedge clk_sys) disable iff (!nrst)
        !if_power_save_n |-> !pd_out[0].oe && !pd_out[0].up;
    endproperty
    a_standby_hiz: assert property (p_standby_hiz) // RL2
        else $error("if detector driven in standby");

    property p_ld_unlock;
        @(posedge clk_sys) disable iff (!nrst)
        if_power_save_n |=> !lock_indicator || st_ff.locked[0];
    endproperty
    a_ld_unlock: assert property (p_ld_unlock) // RL9
        else $error("lock shown while if unlocked");

    property p_both_standby;
        @(posedge clk_sys) disable iff (!nrst)
        (!if_power_save_n && !rf_power_save_n) |=> lock_indicator;
    endproperty
    a_both_standby: assert property (p_both_standby) // RL9
        else $error("lock low with both in standby");

    property p_wake_cap;
        @(posedge clk_sys) disable iff (!nrst)
        (st_ff.wake[1] != 3'h0) |-> !(pd_out[1].up && !pd_out[1].dn
            && st_ff.plen[1] > plls_pkg::START_CAP);
    endproperty
    a_wake_cap: assert property (p_wake_cap) // RL3
        else $error("rf pulse not limited after wake");

    property p_shift;
        @(posedge clk_sys) disable iff (!nrst)
        (ser_in.clk && !st_ff.clk_q) |=> st_ff.shreg[0] == $past(ser_in.data);
    endproperty
    a_shift: assert property (p_shift) // RL7
        else $error("serial bit not captured");

    property p_latch;
        @(posedge clk_sys) disable iff (!nrst)
        (ser_in.load_strobe && !st_ff.strobe_q && st_ff.shreg[1:0] == 2'h3)
        |=> st_ff.lat.rf_div == $past(st_ff.shreg[plls_pkg::SR_W-1:2]);
    endproperty
    a_latch: assert property (p_latch) // RL15
        else $error("rf divider latch not loaded");

    property p_lock_drop;
        @(posedge clk_sys) disable iff (!nrst)
        (if_power_save_n && st_ff.up[0] && cmp_edge[0] && !ref_edge[0]
         && st_ff.err[0] >= plls_pkg::UPPER_WIN - 4'h1)
        |=> !st_ff.locked[0];
    endproperty
    a_lock_drop: assert property (p_lock_drop) // RL10
        else $error("lock kept with large error");

    property p_wake_indep;
        @(posedge clk_sys) disable iff (!nrst)
        (rf_power_save_n && $rose(if_power_save_n)) |=> pd_out[1].oe;
    endproperty
    a_wake_indep: assert property (p_wake_indep) // RL17
        else $error("rf disturbed by if wake");
endmodule : plls_core

// ### verif/plls_host_model.sv
// plls_host_model: host side driving the serial pins and standby inputs
// assumes the bench calls its tasks; pins change at falling clk_sys edges
`timescale 1ns/1ns
module plls_host_model (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // pins toward the core
    output plls_pkg::plls_serial_t ser,
    output logic                   if_power_save_n,
    output logic                   rf_power_save_n
);
    realtime t_load = 0.0;

    initial begin
        ser = '0;
        if_power_save_n = 1'b0;
        rf_power_save_n = 1'b0;
    end

    // 1 us of settled supply before any shifting
    task automatic power_up();
        wait (nrst === 1'b1);
        repeat (126) @(negedge clk_sys);
    endtask : power_up

    // serial clock stands low outside frames
    task automatic send_word(input logic [22:0] w);
        for (int i = 22; i >= 0; i--) begin
            @(negedge clk_sys);
            ser.data = w[i];
            ser.clk = 1'b0;
            @(negedge clk_sys);
            ser.clk = 1'b1;
        end
        @(negedge clk_sys);
        ser.clk = 1'b0;
        ser.load_strobe = 1'b1;
        @(negedge clk_sys);
        ser.load_strobe = 1'b0;
        ser.data = ~ser.data; // hold time over, old bit gone
        t_load = $realtime;
    endtask : send_word

    task automatic set_ps(input int s, input logic v);
        if (v) while ($realtime < t_load + 100.0) @(negedge clk_sys);
        @(negedge clk_sys);
        if (s == 0) if_power_save_n = v;
        else rf_power_save_n = v;
    endtask : set_ps
endmodule : plls_host_model

// ### verif/test_plls_core.sv
// test_plls_core: self-checking bench for the dual pll control core
// assumes the host model owns serial and standby pins
`timescale 1ns/1ns
module test_plls_core;
    logic                   clk_sys;
    logic                   nrst;
    plls_pkg::plls_serial_t ser;
    logic                   if_power_save_n;
    logic                   rf_power_save_n;
    logic [1:0]             ref_edge;
    logic [1:0]             cmp_edge;
    plls_pkg::plls_pd_t     pd_out [2];
    plls_pkg::plls_latch_t  latches;
    logic                   lock_indicator;
    int                     fail_count = 0;
    int                     n_compared = 0;
    int                     cycles = 0;
    int                     up_n;
    int                     dn_n;

    plls_core dut_u (
        .clk_sys          (clk_sys),
        .nrst             (nrst),
        .ser_in           (ser),
        .if_power_save_n  (if_power_save_n),
        .rf_power_save_n  (rf_power_save_n),
        .reference_osc_in (1'b0),
        .ref_edge         (ref_edge),
        .cmp_edge         (cmp_edge),
        .pd_out           (pd_out),
        .latches          (latches),
        .lock_indicator   (lock_indicator)
    );
    plls_host_model host_u (
        .clk_sys         (clk_sys),
        .nrst            (nrst),
        .ser             (ser),
        .if_power_save_n (if_power_save_n),
        .rf_power_save_n (rf_power_save_n)
    );

    task automatic check(input logic [83:0] seen, input logic [83:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // one reference edge, comparison edge err cycles later; legs counted
    task automatic compare(input int s, input int err);
        up_n = 0;
        dn_n = 0;
        for (int i = 0; i <= err + 5; i++) begin
            @(negedge clk_sys);
            up_n += int'(pd_out[s].up === 1'b1);
            dn_n += int'(pd_out[s].dn === 1'b1);
            ref_edge[s] = (i == 0);
            cmp_edge[s] = (i == err);
        end
    endtask : compare

    task automatic t_serial();
        logic [20:0] pl [4] = '{21'h1a5a5a, 21'h05c3e1, 21'h1ffff0, 21'h00000f};
        for (int k = 0; k < 4; k++) begin
            host_u.send_word({pl[k], 2'(k)});
        end
        @(negedge clk_sys);
        check(latches, {pl[0], pl[1], pl[2], pl[3]});
        host_u.send_word({21'h000000, plls_pkg::SEL_IF_REF});
        @(negedge clk_sys);
        check(latches, {21'h000000, pl[1], pl[2], pl[3]});
        $display("test serial done");
    endtask : t_serial

    task automatic t_wake();
        host_u.set_ps(0, 1'b1);
        repeat (3) @(negedge clk_sys);
        check({pd_out[0].oe, pd_out[1].oe}, 2'h2);
        for (int k = 0; k < 4; k++) begin
            compare(0, 6);
            check(up_n, 1);
        end
        check(lock_indicator, 1'b0);
        $display("test wake done");
    endtask : t_wake

    task automatic t_lock();
        compare(0, 1);
        compare(0, 1);
        check(lock_indicator, 1'b0);
        compare(0, 1);
        check(lock_indicator, 1'b1);
        compare(0, 1);
        check(dn_n != 0, 1'b1);
        compare(0, 2);
        check(lock_indicator, 1'b0);
        $display("test lock done");
    endtask : t_lock

    task automatic t_rf();
        host_u.set_ps(1, 1'b1);
        repeat (3) @(negedge clk_sys);
        check({pd_out[0].oe, pd_out[1].oe}, 2'h3);
        // if sleeps and wakes while rf runs: rf enable must not blink
        host_u.set_ps(0, 1'b0);
        repeat (2) @(negedge clk_sys);
        check({pd_out[0].oe, pd_out[1].oe}, 2'h1);
        host_u.set_ps(0, 1'b1);
        repeat (3) compare(0, 1);
        check(pd_out[1].oe, 1'b1);
        compare(1, 6);
        check(lock_indicator, 1'b0);
        host_u.set_ps(1, 1'b0);
        repeat (3) @(negedge clk_sys);
        check(lock_indicator, 1'b1);
        check(pd_out[1].oe, 1'b0);
        $display("test standby mix done");
    endtask : t_rf

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // run needs under 1500 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        nrst = 1'b0;
        ref_edge = 2'h0;
        cmp_edge = 2'h0;
        repeat (4) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (2) @(negedge clk_sys);
        check(latches, '0);
        check(lock_indicator, 1'b1);
        check({pd_out[0].oe, pd_out[1].oe}, 2'h0);
        $display("test reset done");
        host_u.power_up();
        t_serial();
        t_wake();
        t_lock();
        t_rf();
        final_report();
    end
endmodule : test_plls_core
